// File: scp_params.svh
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

// ----------------------------------------
// Register bank
// ----------------------------------------
`define SCP_TOP_ADDR 8'h14
`define SCP_NUM_REGS 21
`define SCP_REG_RESET 8'h00
`define SCP_PTR_RESET 8'h00

// ----------------------------------------
// Slave address and last bit index of a byte
// ----------------------------------------
`define SCP_SLAVE_HI 6'h26
`define SCP_BIT_LAST 3'h7

`endif

// File: scp_pkg.sv
package scp_pkg;
  // Link-side sequencer states, one-hot
  typedef enum logic [7:0] {
    SCP_IDLE  = 8'h01,
    SCP_ADDR  = 8'h02,
    SCP_REG   = 8'h04,
    SCP_WDATA = 8'h08,
    SCP_ACK   = 8'h10,
    SCP_READ  = 8'h20,
    SCP_MACK  = 8'h40,
    SCP_WAIT  = 8'h80
  } scp_state_e;

  typedef logic [7:0] scp_byte_t;
endpackage : scp_pkg

// File: scp_sync2.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Two-flop level synchroniser
// ----------------------------------------
module scp_sync2 #(
  parameter int W = 1
) (
  input wire logic clk, // Destination clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [W-1:0] d, // Level from another domain or a pin
  output logic [W-1:0] q // Synchronised level
);
  logic [W-1:0] meta;

  // The first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : scp_sync2

`default_nettype wire

// File: scp_xfer.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Toggle handshake carrying one register access across clocks
// ----------------------------------------
module scp_xfer (
  input wire logic src_clk, // Link-side clock
  input wire logic src_rst_n, // Link-side reset, active low
  input wire logic src_start, // One-cycle request
  input wire logic src_write, // 1 write, 0 read
  input wire logic [7:0] src_addr, // Register index
  input wire logic [7:0] src_wdata, // Write data
  output logic src_done, // One-cycle completion pulse
  output logic [7:0] src_rdata, // Read data of last access
  input wire logic dst_clk, // System clock
  input wire logic dst_rst_n, // System reset, active low
  output logic dst_req, // One-cycle access pulse
  output logic dst_write, // Held write flag
  output logic [7:0] dst_addr, // Held register index
  output logic [7:0] dst_wdata, // Held write data
  input wire logic [7:0] dst_rdata // Register contents at dst_addr
);
  logic req_tgl, next_req_tgl, ack_s, ack_prev;
  logic pl_write, next_pl_write;
  logic [7:0] pl_addr, next_pl_addr, pl_wdata, next_pl_wdata, next_src_rdata;
  logic ack_tgl, next_ack_tgl, req_s, req_prev;
  logic [7:0] hold, next_hold;

  scp_sync2 #(.W(1)) u_req_sync (.clk(dst_clk), .rst_n(dst_rst_n), .d(req_tgl), .q(req_s));
  scp_sync2 #(.W(1)) u_ack_sync (.clk(src_clk), .rst_n(src_rst_n), .d(ack_tgl), .q(ack_s));

  // Payload stays still while the toggle crosses, so it needs no synchroniser
  assign src_done = ack_s ^ ack_prev;
  assign dst_req = req_s ^ req_prev;
  assign dst_write = pl_write;
  assign dst_addr = pl_addr;
  assign dst_wdata = pl_wdata;

  // Source side next values
  always_comb begin
    next_req_tgl = req_tgl;
    next_pl_write = pl_write;
    next_pl_addr = pl_addr;
    next_pl_wdata = pl_wdata;
    next_src_rdata = src_done ? hold : src_rdata;
    if (src_start) begin
      next_req_tgl = ~req_tgl;
      next_pl_write = src_write;
      next_pl_addr = src_addr;
      next_pl_wdata = src_wdata;
    end
  end

  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      req_tgl <= 1'b0;
      ack_prev <= 1'b0;
      pl_write <= 1'b0;
      pl_addr <= 8'h00;
      pl_wdata <= 8'h00;
      src_rdata <= 8'h00;
    end else begin
      req_tgl <= next_req_tgl;
      ack_prev <= ack_s;
      pl_write <= next_pl_write;
      pl_addr <= next_pl_addr;
      pl_wdata <= next_pl_wdata;
      src_rdata <= next_src_rdata;
    end
  end

  // Destination side: capture read data and answer with the ack toggle in the same cycle
  always_comb begin
    next_hold = dst_req ? dst_rdata : hold;
    next_ack_tgl = dst_req ? req_s : ack_tgl;
  end

  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      req_prev <= 1'b0;
      hold <= 8'h00;
      ack_tgl <= 1'b0;
    end else begin
      req_prev <= req_s;
      hold <= next_hold;
      ack_tgl <= next_ack_tgl;
    end
  end
endmodule : scp_xfer

`default_nettype wire

// File: scp_serial_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "scp_params.svh"

module scp_serial_port
  import scp_pkg::*;
(
  input wire logic clk_sys, // System clock, 25 MHz
  input wire logic reset_n, // Async reset, active low
  input wire logic link_clk, // Oversampling clock of the serial side
  input wire logic scl_in, // Serial clock pin level
  input wire logic sda_in, // Serial data pin level
  output logic sda_out, // Data pin drive level, always low
  output logic sda_oe, // High while pulling the data pin low
  input wire logic slave_address_select_pins, // Address low bit strap
  output logic [8*`SCP_NUM_REGS-1:0] ctrl_regs, // Register bank, index 0 in low byte
  output logic reg_wr_strobe, // One-cycle pulse on a register write
  output logic [7:0] reg_wr_addr // Index of the last write
);
  // ----------------------------------------
  // Link-side synchronisers
  // ----------------------------------------
  logic link_rst_n, scl_s, sda_s, sel_s, scl_d, sda_d;
  logic [2:0] pins_n;
  logic start_det, stop_det, scl_rise, scl_fall;

  scp_sync2 #(.W(1)) u_rst_sync (.clk(link_clk), .rst_n(reset_n), .d(1'b1), .q(link_rst_n));
  scp_sync2 #(.W(3)) u_pin_sync (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d(~{scl_in, sda_in, slave_address_select_pins}),
    .q(pins_n)
  );

  // Kept inverted so that the flops' reset reads as an idle pulled-up bus, with no false edge after reset
  assign {scl_s, sda_s, sel_s} = ~pins_n;

  // Edge history; reset high matches an idle pulled-up bus
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Data moving while clock stays high marks start or stop
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign sda_out = 1'b0;

  // ----------------------------------------
  // Link-side sequencer
  // ----------------------------------------
  scp_state_e state, next_state, after_st, next_after_st;
  logic [2:0] bit_cnt, next_bit_cnt;
  scp_byte_t shreg, next_shreg, ptr, next_ptr, byte_in, ptr_inc;
  logic [1:0] phase, next_phase;
  logic ack_ok, next_ack_ok, next_sda_oe;
  logic req_go, req_we;
  scp_byte_t req_addr, req_wd, rd_data;

  // Saturating advance of the register pointer
  assign ptr_inc = (ptr == `SCP_TOP_ADDR) ? ptr : ptr + 8'h01;

  // Next values of the sequencer
  always_comb begin
    next_state = state;
    next_after_st = after_st;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_phase = phase;
    next_ack_ok = ack_ok;
    next_sda_oe = sda_oe;
    req_go = 1'b0;
    req_we = 1'b0;
    req_addr = ptr;
    req_wd = shreg;
    byte_in = {shreg[6:0], sda_s};
    if (stop_det) begin
      next_state = SCP_IDLE;
      next_sda_oe = 1'b0;
    end else if (start_det) begin
      // Also taken mid-transfer, which gives the repeated start
      next_state = SCP_ADDR;
      next_bit_cnt = 3'h0;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        SCP_ADDR, SCP_REG, SCP_WDATA: begin
          if (scl_rise) begin
            next_shreg = byte_in;
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == `SCP_BIT_LAST) begin
              next_state = SCP_ACK;
              next_phase = 2'h0;
              if (state == SCP_ADDR) begin
                next_ack_ok = (byte_in[7:1] == {`SCP_SLAVE_HI, sel_s});
                if (!next_ack_ok) begin
                  next_after_st = SCP_WAIT;
                end else if (byte_in[0]) begin
                  next_after_st = SCP_READ;
                  req_go = 1'b1;
                end else begin
                  next_after_st = SCP_REG;
                end
              end else if (state == SCP_REG) begin
                next_ack_ok = (byte_in <= `SCP_TOP_ADDR);
                next_after_st = next_ack_ok ? SCP_WDATA : SCP_WAIT;
                if (next_ack_ok) begin
                  next_ptr = byte_in;
                end
              end else begin
                next_ack_ok = 1'b1;
                next_after_st = SCP_WDATA;
                req_go = 1'b1;
                req_we = 1'b1;
                req_wd = byte_in;
                next_ptr = ptr_inc;
              end
            end
          end
        end
        SCP_ACK: begin
          if (scl_fall) begin
            if (phase == 2'h0) begin
              next_sda_oe = ack_ok;
              next_phase = 2'h1;
            end else begin
              // Refused bytes never pull the line, so it stays high
              next_sda_oe = 1'b0;
              next_state = after_st;
              next_bit_cnt = 3'h0;
              if (after_st == SCP_READ) begin
                next_shreg = rd_data;
                next_sda_oe = ~rd_data[7];
                next_ptr = ptr_inc;
                req_go = 1'b1;
                req_addr = ptr_inc;
              end
            end
          end
        end
        SCP_READ: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 3'h1;
            if (bit_cnt == `SCP_BIT_LAST) begin
              next_state = SCP_MACK;
              next_phase = 2'h0;
            end
          end else if (scl_fall) begin
            next_shreg = {shreg[6:0], 1'b0};
            next_sda_oe = ~shreg[6];
          end
        end
        SCP_MACK: begin
          if (phase == 2'h0 && scl_fall) begin
            next_sda_oe = 1'b0;
            next_phase = 2'h1;
          end else if (phase == 2'h1 && scl_rise) begin
            // A released line here means the master wants no more data
            next_state = sda_s ? SCP_WAIT : SCP_MACK;
            next_phase = 2'h2;
          end else if (phase == 2'h2 && scl_fall) begin
            next_state = SCP_READ;
            next_bit_cnt = 3'h0;
            next_shreg = rd_data;
            next_sda_oe = ~rd_data[7];
            next_ptr = ptr_inc;
            req_go = 1'b1;
            req_addr = ptr_inc;
          end
        end
        SCP_IDLE, SCP_WAIT: begin
          next_sda_oe = 1'b0;
        end
        default: begin
          next_state = SCP_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state <= SCP_IDLE;
      after_st <= SCP_WAIT;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      ptr <= `SCP_PTR_RESET;
      phase <= 2'h0;
      ack_ok <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      state <= next_state;
      after_st <= next_after_st;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      phase <= next_phase;
      ack_ok <= next_ack_ok;
      sda_oe <= next_sda_oe;
    end
  end

  // ----------------------------------------
  // Crossing into the system domain
  // ----------------------------------------
  logic sys_req, sys_write;
  scp_byte_t sys_addr, sys_wdata, sys_rdata;

  // Prefetch keeps one byte ahead, so a read never waits on the crossing
  scp_xfer u_xfer (
    .src_clk(link_clk),
    .src_rst_n(link_rst_n),
    .src_start(req_go),
    .src_write(req_we),
    .src_addr(req_addr),
    .src_wdata(req_wd),
    .src_done(), // Request spacing already exceeds the round trip
    .src_rdata(rd_data),
    .dst_clk(clk_sys),
    .dst_rst_n(reset_n),
    .dst_req(sys_req),
    .dst_write(sys_write),
    .dst_addr(sys_addr),
    .dst_wdata(sys_wdata),
    .dst_rdata(sys_rdata)
  );

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  scp_byte_t regs [`SCP_NUM_REGS];
  scp_byte_t next_regs [`SCP_NUM_REGS];
  logic next_wr_strobe, addr_ok;
  scp_byte_t next_wr_addr;

  // Indices above the top are never sent, but are guarded anyway
  assign addr_ok = (sys_addr <= `SCP_TOP_ADDR);
  assign sys_rdata = addr_ok ? regs[sys_addr[4:0]] : 8'h00;

  // Next bank contents
  always_comb begin
    for (int i = 0; i < `SCP_NUM_REGS; i++) begin
      next_regs[i] = regs[i];
    end
    next_wr_strobe = 1'b0;
    next_wr_addr = reg_wr_addr;
    if (sys_req && sys_write && addr_ok) begin
      next_regs[sys_addr[4:0]] = sys_wdata;
      next_wr_strobe = 1'b1;
      next_wr_addr = sys_addr;
    end
  end

  // Bank registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `SCP_NUM_REGS; i++) begin
        regs[i] <= `SCP_REG_RESET;
      end
      reg_wr_strobe <= 1'b0;
      reg_wr_addr <= 8'h00;
    end else begin
      for (int i = 0; i < `SCP_NUM_REGS; i++) begin
        regs[i] <= next_regs[i];
      end
      reg_wr_strobe <= next_wr_strobe;
      reg_wr_addr <= next_wr_addr;
    end
  end

  // Flatten the bank onto the output bus
  always_comb begin
    ctrl_regs = '0;
    for (int i = 0; i < `SCP_NUM_REGS; i++) begin
      ctrl_regs[i*8 +: 8] = regs[i];
    end
  end
endmodule : scp_serial_port

`default_nettype wire

// File: scp_bus_master.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Behavioural two-wire bus master
// ----------------------------------------
module scp_bus_master (
  input wire logic clk, // Timing reference
  input wire logic sda, // Resolved data line
  output var logic scl, // Serial clock, stands high between frames
  output var logic pull // High while pulling data low
);
  // Idle bus: both lines high
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end

  // One clock phase of 1.2 us, longer than the crossing latency
  task automatic half();
    repeat (30) @(negedge clk);
  endtask : half

  // Data is released a little after the clock falls, never with it
  task automatic start();
    repeat (4) @(negedge clk);
    pull = 1'b0;
    half();
    scl = 1'b1;
    half();
    pull = 1'b1;
    half();
    scl = 1'b0;
  endtask : start

  task automatic stop();
    repeat (4) @(negedge clk);
    pull = 1'b1;
    half();
    scl = 1'b1;
    half();
    pull = 1'b0;
    half();
  endtask : stop

  // Eight bits and the acknowledge slot; each slot is sampled late in the high phase
  task automatic xbyte(input logic [7:0] tx, input logic ack, output logic [7:0] rx, output logic ack_rx);
    logic [8:0] sh;
    sh = {tx, ack};
    for (int i = 8; i >= 0; i--) begin
      repeat (4) @(negedge clk);
      pull = !sh[i];
      half();
      scl = 1'b1;
      half();
      sh[i] = sda;
      scl = 1'b0;
    end
    rx = sh[8:1];
    ack_rx = sh[0];
  endtask : xbyte
endmodule : scp_bus_master
`default_nettype wire

// File: scp_serial_port_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "scp_params.svh"

// ----------------------------------------
// Port checker
// ----------------------------------------
module scp_serial_port_checker
  import scp_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic link_clk, // Link clock
  input wire logic scl_in, // Clock pin
  input wire logic sda_in, // Data pin
  input wire logic sda_out, // Data drive level
  input wire logic sda_oe, // Data drive enable
  input wire logic slave_address_select_pins, // Address strap
  input wire logic [8*`SCP_NUM_REGS-1:0] ctrl_regs, // Register bank
  input wire logic reg_wr_strobe, // Write pulse
  input wire logic [7:0] reg_wr_addr // Last write index
);
  // Pin conditions in the link domain
  sequence stop_seen;
    scl_in && $rose(sda_in);
  endsequence
  sequence drive_begins;
    $rose(sda_oe);
  endsequence

  AST_STROBE_ONE: assert property (
    @(posedge clk_sys) disable iff (!reset_n) reg_wr_strobe |=> !reg_wr_strobe)
    else $error("write strobe longer than one cycle");
  AST_WADDR_TOP: assert property (
    @(posedge clk_sys) disable iff (!reset_n) reg_wr_strobe |-> reg_wr_addr <= `SCP_TOP_ADDR)
    else $error("write beyond top register");
  AST_REGS_ON_STROBE: assert property (
    @(posedge clk_sys) disable iff (!reset_n) $changed(ctrl_regs) |-> reg_wr_strobe)
    else $error("register bank changed without a write");
  AST_WADDR_ON_STROBE: assert property (
    @(posedge clk_sys) disable iff (!reset_n) $changed(reg_wr_addr) |-> reg_wr_strobe)
    else $error("write index changed without a write");
  AST_OE_SCL_LOW: assert property (
    @(posedge link_clk) disable iff (!reset_n) $changed(sda_oe) |-> !scl_in)
    else $error("data drive changed while clock high");
  AST_OE_STANDS: assert property (
    @(posedge link_clk) disable iff (!reset_n) drive_begins |-> sda_oe [*8])
    else $error("data drive too short");
  AST_STOP_FREE: assert property (
    @(posedge link_clk) disable iff (!reset_n) stop_seen |-> !sda_oe [*4])
    else $error("data driven after stop");
  AST_DRIVE_LOW: assert property (
    @(posedge link_clk) disable iff (!reset_n) sda_oe |-> !sda_out)
    else $error("data drive not low");
endmodule : scp_serial_port_checker

bind scp_serial_port scp_serial_port_checker chk_i (.clk_sys(clk_sys), .reset_n(reset_n), .link_clk(link_clk),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .slave_address_select_pins(slave_address_select_pins), .ctrl_regs(ctrl_regs),
  .reg_wr_strobe(reg_wr_strobe), .reg_wr_addr(reg_wr_addr));
`default_nettype wire

// File: test_serial_control_register_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "scp_params.svh"

module test_serial_control_register_port
  import scp_pkg::*;
;
  logic clk_sys, reset_n, link_clk, sel, scl, pull, sda, sda_out, sda_oe, reg_wr_strobe;
  logic [8*`SCP_NUM_REGS-1:0] ctrl_regs;
  logic [7:0] reg_wr_addr, b;
  logic [31:0] seed = 32'h5c318cc5;
  scp_byte_t exp_reg [`SCP_NUM_REGS];
  int err_count = 0;
  int tests_run = 0;
  int strobes = 0;

  // Write pulses counted mid-cycle, where the one-cycle strobe stands settled
  always @(negedge clk_sys) begin
    if (reg_wr_strobe === 1'b1) strobes++;
  end

  // Open-drain data line with pull-up
  assign sda = !pull && (!sda_oe || sda_out);

  // Clocks of unrelated phase
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    link_clk = 1'b0;
    #1;
    forever #3 link_clk = ~link_clk;
  end

  scp_serial_port uut (.clk_sys(clk_sys), .reset_n(reset_n), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .slave_address_select_pins(sel), .ctrl_regs(ctrl_regs),
    .reg_wr_strobe(reg_wr_strobe), .reg_wr_addr(reg_wr_addr));
  scp_bus_master master (.clk(clk_sys), .sda(sda), .scl(scl), .pull(pull));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Pointer advance, holding at the top register
  function automatic logic [7:0] nxt(input logic [7:0] a);
    return (a >= `SCP_TOP_ADDR) ? a : a + 8'h01;
  endfunction : nxt

  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    tests_run++;
    if (got !== want) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : chk

  task automatic print_verdict();
    $display("tests %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic check_regs();
    for (int i = 0; i < `SCP_NUM_REGS; i++) chk(ctrl_regs[8*i+:8], exp_reg[i]);
  endtask : check_regs

  // Write n random bytes; a0 other than the strap or a bad base must be refused
  task automatic wr(input logic [7:0] base, input int n, input logic a0);
    logic [7:0] d, rx, a;
    logic ack, ok;
    int s0;
    ok = (a0 === sel) && (base <= `SCP_TOP_ADDR);
    s0 = strobes;
    a = base;
    master.start();
    master.xbyte({`SCP_SLAVE_HI, a0, 1'b0}, 1'b1, rx, ack);
    chk({7'h0, ack}, {7'h0, a0 !== sel});
    master.xbyte(base, 1'b1, rx, ack);
    chk({7'h0, ack}, {7'h0, !ok});
    for (int i = 0; i < n; i++) begin
      d = 8'(xs());
      master.xbyte(d, 1'b1, rx, ack);
      chk({7'h0, ack}, {7'h0, !ok});
      if (ok) begin
        exp_reg[a] = d;
        chk(reg_wr_addr, a);
        a = nxt(a);
      end
    end
    master.stop();
    chk(8'(strobes - s0), ok ? 8'(n) : 8'h00);
    check_regs();
  endtask : wr

  // Set the base, turn round with a repeated start, read n bytes, NACK the last
  task automatic rd(input logic [7:0] base, input int n);
    logic [7:0] rx, a;
    logic ack;
    a = base;
    master.start();
    master.xbyte({`SCP_SLAVE_HI, sel, 1'b0}, 1'b1, rx, ack);
    master.xbyte(base, 1'b1, rx, ack);
    chk({7'h0, ack}, 8'h00);
    master.start();
    master.xbyte({`SCP_SLAVE_HI, sel, 1'b1}, 1'b1, rx, ack);
    chk({7'h0, ack}, 8'h00);
    for (int i = 0; i < n; i++) begin
      master.xbyte(8'hff, i == n - 1, rx, ack);
      chk(rx, exp_reg[a]);
      a = nxt(a);
    end
    repeat (8) @(negedge clk_sys);
    chk({7'h0, sda_oe}, 8'h00);
    master.stop();
  endtask : rd

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    sel = 1'b0;
    foreach (exp_reg[i]) exp_reg[i] = `SCP_REG_RESET;
    repeat (5) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (10) @(negedge clk_sys);
    check_regs();
    wr(8'h05, 1, 1'b0);
    rd(8'h05, 1);
    wr(8'h12, 4, 1'b0); // Runs past the top register
    rd(8'h12, 4);
    wr(8'h15, 1, 1'b0); // Base one above the top
    wr(8'h03, 1, 1'b1); // Other device on the bus
    sel = 1'b1;
    repeat (4) @(negedge clk_sys);
    wr(8'h00, 2, 1'b1);
    rd(8'h00, 2);
    repeat (4) begin
      b = 8'(xs() % 22);
      wr(b, 1 + int'(xs() % 3), sel);
      rd(b > `SCP_TOP_ADDR ? `SCP_TOP_ADDR : b, 1 + int'(xs() % 3));
    end
    print_verdict();
  end

  // Watchdog well beyond the expected run of under 2 ms
  initial begin
    #3600000;
    err_count++;
    print_verdict();
  end
endmodule : test_serial_control_register_port
`default_nettype wire
